// file: hdl/srb_sfr_bank.sv
// special function register bank with per-source reset handling
`timescale 1ns/1ps
`include "srb_consts.svh"

module srb_sfr_bank
    import srb_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire srb_bus_req_s     sfr_req,
    output logic [7:0]            sfr_rdata,
    input  wire srb_reset_evt_s   reset_evt,
    input  wire logic             brownout_irq,
    input  wire logic [7:0]       factory_trim,
    output srb_port_mode_s [3:0]  port_mode,
    output srb_wdog_ctl_s         wdog_ctl,
    output srb_trim_s             osc_trim,
    output srb_reset_cause_s      reset_cause,
    output logic [7:0]            rtc_ctl,
    output logic [7:0]            spi_ctl,
    output logic [7:0]            pwr_ctl_ext,
    output logic [7:0]            serial_ext_status,
    output logic [7:0]            timer_ctl,
    output logic [7:0]            timer_aux_mode,
    output logic [7:0]            port0_input_disable
);

    // ------------------------------------------------------------------------
    // register table
    // ------------------------------------------------------------------------
    localparam int NREG = 32;

    // reset values and masks carry the field layouts
    // and
    localparam logic [23:0] REG_TABLE [NREG] = '{
        `SRB_REG_STKPTR, `SRB_REG_P0MA,   `SRB_REG_P0MB,    `SRB_REG_PWRCTL,
        `SRB_REG_TCTL,   `SRB_REG_TMODE,  `SRB_REG_T0LO,    `SRB_REG_T1LO,
        `SRB_REG_T0HI,   `SRB_REG_T1HI,   `SRB_REG_TAUX,    `SRB_REG_P1MA,
        `SRB_REG_P1MB,   `SRB_REG_SCTL,   `SRB_REG_SERBUF,  `SRB_REG_P2MA,
        `SRB_REG_P2MB,   `SRB_REG_SMADDR, `SRB_REG_P3MA,    `SRB_REG_P3MB,
        `SRB_REG_PCEXT,  `SRB_REG_SMMASK, `SRB_REG_SXSTAT,  `SRB_REG_WDLOAD,
        `SRB_REG_PSTAT,  `SRB_REG_RTCCTL, `SRB_REG_RTCHI,   `SRB_REG_RTCLO,
        `SRB_REG_SPISTAT,`SRB_REG_SPICTL, `SRB_REG_SPIDATA, `SRB_REG_P0INDIS
    };

    localparam int IDX_P0MA   = 1;
    localparam int IDX_P0MB   = 2;
    localparam int IDX_TCTL   = 4;
    localparam int IDX_TAUX   = 10;
    localparam int IDX_P1MA   = 11;
    localparam int IDX_P1MB   = 12;
    localparam int IDX_P2MA   = 15;
    localparam int IDX_P2MB   = 16;
    localparam int IDX_P3MA   = 18;
    localparam int IDX_P3MB   = 19;
    localparam int IDX_PCEXT  = 20;
    localparam int IDX_SXSTAT = 22;
    localparam int IDX_RTCCTL = 25;
    localparam int IDX_SPICTL = 29;
    localparam int IDX_P0IND  = 31;

    // ------------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------------
    logic              any_rst;
    logic              wr_trim;
    logic              wr_wdctl;
    logic              wr_rcause;
    logic [NREG-1:0]   wr_hit;
    logic [7:0]        rd_term [NREG];
    logic [7:0]        rd_plain;
    logic [7:0]        rdata_d;
    logic [7:0]        regs_q [NREG];
    logic [7:0]        rdata_q;
    logic              por_pending_q;
    srb_wdog_ctl_s     wdctl_q;
    srb_trim_s         trim_q;
    srb_reset_cause_s  rcause_q;
    srb_reset_cause_s  rcause_d;

    assign any_rst   = |reset_evt;
    assign wr_trim   = sfr_req.wr && (sfr_req.addr == `SRB_ADDR_TRIM);
    assign wr_wdctl  = sfr_req.wr && (sfr_req.addr == `SRB_ADDR_WDCTL);
    assign wr_rcause = sfr_req.wr && (sfr_req.addr == `SRB_ADDR_RCAUSE);

    // ------------------------------------------------------------------------
    // plain registers
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            localparam logic [7:0] ADDR = REG_TABLE[gi][23:16];
            localparam logic [7:0] MASK = REG_TABLE[gi][15:8];
            localparam logic [7:0] RSTV = REG_TABLE[gi][7:0];

            assign wr_hit[gi]  = sfr_req.wr && (sfr_req.addr == ADDR);
            assign rd_term[gi] = (sfr_req.addr == ADDR) ? (regs_q[gi] & MASK) : 8'h00;

            // every reset source brings these back; unused bits never store
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[gi] <= RSTV;
                end else if (any_rst) begin
                    regs_q[gi] <= RSTV;
                end else if (wr_hit[gi]) begin
                    regs_q[gi] <= sfr_req.wdata & MASK;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_plain = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            rd_plain = rd_plain | rd_term[i];
        end
    end

    // ------------------------------------------------------------------------
    // power-on load of the factory trim
    // ------------------------------------------------------------------------
    // the strap is caught by a clocked edge after release, not by the reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_pending_q <= 1'b1;
        end else begin
            por_pending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // oscillator trim
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_q <= srb_trim_s'(`SRB_RST_TRIM);
        end else if (por_pending_q || reset_evt.wdog) begin
            trim_q <= srb_trim_s'(factory_trim);
        end else if (wr_trim) begin
            trim_q <= srb_trim_s'(sfr_req.wdata);
        end
    end

    // ------------------------------------------------------------------------
    // watchdog control
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdctl_q <= srb_wdog_ctl_s'(`SRB_RST_WDCTL);
        end else if (reset_evt.wdog) begin
            wdctl_q <= srb_wdog_ctl_s'(`SRB_RST_WDCTL);
            wdctl_q.watchdog_timeout_flag <= 1'b1;
        end else if (wr_wdctl) begin
            // other reset sources fall through and leave it alone
            wdctl_q <= srb_wdog_ctl_s'(sfr_req.wdata & `SRB_MASK_WDCTL);
        end
    end

    // ------------------------------------------------------------------------
    // reset cause
    // ------------------------------------------------------------------------
    // hardware sets win over a software write in the same cycle
    always_comb begin
        rcause_d = rcause_q;
        if (wr_rcause) begin
            rcause_d = srb_reset_cause_s'(sfr_req.wdata & `SRB_MASK_RCAUSE);
        end
        if (reset_evt.brownout) begin
            rcause_d.brownout_reset_flag = 1'b1;
        end
        if (reset_evt.brk) begin
            rcause_d.break_reset_flag = 1'b1;
        end
        if (reset_evt.wdog) begin
            rcause_d.watchdog_reset_flag = 1'b1;
        end
        if (reset_evt.software) begin
            rcause_d.software_reset_flag = 1'b1;
        end
        if (reset_evt.external) begin
            rcause_d.external_reset_flag = 1'b1;
        end
        if (brownout_irq) begin
            rcause_d.brownout_irq_flag = 1'b1;
        end
        rcause_d.unused = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rcause_q <= srb_reset_cause_s'(`SRB_RST_RCAUSE);
        end else begin
            rcause_q <= rcause_d;
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    // feed registers are write-only and read as zero, as do unmapped addresses
    always_comb begin
        case (sfr_req.addr)
            `SRB_ADDR_TRIM:   rdata_d = trim_q;
            `SRB_ADDR_WDCTL:  rdata_d = wdctl_q & `SRB_MASK_WDCTL;
            `SRB_ADDR_RCAUSE: rdata_d = rcause_q & `SRB_MASK_RCAUSE;
            default:          rdata_d = rd_plain;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign sfr_rdata           = rdata_q;
    assign port_mode[0]        = {regs_q[IDX_P0MA], regs_q[IDX_P0MB]};
    assign port_mode[1]        = {regs_q[IDX_P1MA], regs_q[IDX_P1MB]};
    assign port_mode[2]        = {regs_q[IDX_P2MA], regs_q[IDX_P2MB]};
    assign port_mode[3]        = {regs_q[IDX_P3MA], regs_q[IDX_P3MB]};
    assign wdog_ctl            = wdctl_q;
    assign osc_trim            = trim_q;
    assign reset_cause         = rcause_q;
    assign rtc_ctl             = regs_q[IDX_RTCCTL];
    assign spi_ctl             = regs_q[IDX_SPICTL];
    assign pwr_ctl_ext         = regs_q[IDX_PCEXT];
    assign serial_ext_status   = regs_q[IDX_SXSTAT];
    assign timer_ctl           = regs_q[IDX_TCTL];
    assign timer_aux_mode      = regs_q[IDX_TAUX];
    assign port0_input_disable = regs_q[IDX_P0IND];

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_ports_input_after_por;
        @(posedge sys_clk) disable iff (!rst_n)
        por_pending_q |-> (port_mode[0] == 16'hFF00) && (port_mode[1] == 16'hD300)
            && (port_mode[2] == 16'hFF00) && (port_mode[3] == 16'h0300);
    endproperty
    a_ports_input_after_por: assert property (p_ports_input_after_por)
        else $error("port modes not at input-only reset values");

    property p_wdog_reset_value;
        @(posedge sys_clk) disable iff (!rst_n)
        reset_evt.wdog |=> (wdog_ctl == 8'hE7);
    endproperty
    a_wdog_reset_value: assert property (p_wdog_reset_value)
        else $error("watchdog control wrong after watchdog reset");

    property p_wdog_untouched;
        @(posedge sys_clk) disable iff (!rst_n)
        (any_rst && !reset_evt.wdog && !sfr_req.wr && !por_pending_q)
            |=> $stable(wdog_ctl) && $stable(osc_trim);
    endproperty
    a_wdog_untouched: assert property (p_wdog_untouched)
        else $error("other reset changed watchdog control or trim");

    property p_timeout_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        reset_evt.wdog ##1 (!reset_evt.wdog && !wr_wdctl)[*2]
            |-> wdog_ctl.watchdog_timeout_flag;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag)
        else $error("timeout flag lost after watchdog reset");

    property p_trim_load;
        @(posedge sys_clk) disable iff (!rst_n)
        reset_evt.wdog |=> (osc_trim == $past(factory_trim));
    endproperty
    a_trim_load: assert property (p_trim_load)
        else $error("trim not loaded from factory value");

    property p_cause_recorded;
        @(posedge sys_clk) disable iff (!rst_n)
        (reset_evt.external || brownout_irq) |=> (reset_cause.external_reset_flag
            || !$past(reset_evt.external))
            && (reset_cause.brownout_irq_flag || !$past(brownout_irq));
    endproperty
    a_cause_recorded: assert property (p_cause_recorded)
        else $error("reset cause event lost");

    property p_common_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        any_rst |=> (rtc_ctl == 8'h60) && (spi_ctl == 8'h04) && (pwr_ctl_ext == 8'h00)
            && (serial_ext_status == 8'h00) && (timer_aux_mode == 8'h00);
    endproperty
    a_common_reset: assert property (p_common_reset)
        else $error("control registers not at reset values");

    property p_unimpl_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (sfr_req.rd && sfr_req.addr == 8'hF6) |=> (sfr_rdata[7:6] == 2'b00)
            && !sfr_rdata[0] && (port0_input_disable[7:6] == 2'b00);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented input disable bits not zero");

    property p_cause_top_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (sfr_req.rd && sfr_req.addr == `SRB_ADDR_RCAUSE) |=> !sfr_rdata[7];
    endproperty
    a_cause_top_zero: assert property (p_cause_top_zero)
        else $error("reset cause top bit not zero");

    property p_por_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        por_pending_q |-> (reset_cause == `SRB_RST_RCAUSE) && (wdog_ctl == `SRB_RST_WDCTL);
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("power-on values of reset cause or watchdog control wrong");

    property p_por_trim;
        @(posedge sys_clk) disable iff (!rst_n)
        por_pending_q |=> (osc_trim == $past(factory_trim));
    endproperty
    a_por_trim: assert property (p_por_trim)
        else $error("trim not loaded from factory value after power-on");

    property p_wdog_cause;
        @(posedge sys_clk) disable iff (!rst_n)
        reset_evt.wdog |=> reset_cause.watchdog_reset_flag && wdog_ctl.watchdog_run;
    endproperty
    a_wdog_cause: assert property (p_wdog_cause)
        else $error("watchdog reset not recorded");

    property p_ports_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        any_rst |=> (port_mode[0] == 16'hFF00) && (port_mode[1] == 16'hD300)
            && (port_mode[2] == 16'hFF00) && (port_mode[3] == 16'h0300);
    endproperty
    a_ports_reset: assert property (p_ports_reset)
        else $error("port modes not at reset values after reset event");

    property p_timer_ctl_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        any_rst |=> (timer_ctl == 8'h00) && (port0_input_disable == 8'h00);
    endproperty
    a_timer_ctl_reset: assert property (p_timer_ctl_reset)
        else $error("timer control or input disable not cleared by reset");

    property p_aux_masked;
        @(posedge sys_clk) disable iff (!rst_n)
        (sfr_req.wr && (sfr_req.addr == 8'h8F) && !any_rst)
            |=> (timer_aux_mode == ($past(sfr_req.wdata) & 8'h11));
    endproperty
    a_aux_masked: assert property (p_aux_masked)
        else $error("timer aux mode stored unimplemented bits");

    property p_input_disable_masked;
        @(posedge sys_clk) disable iff (!rst_n)
        (sfr_req.wr && (sfr_req.addr == 8'hF6) && !any_rst)
            |=> (port0_input_disable == ($past(sfr_req.wdata) & 8'h3E));
    endproperty
    a_input_disable_masked: assert property (p_input_disable_masked)
        else $error("input disable stored unimplemented bits");

endmodule // srb_sfr_bank

// file: inc/srb_consts.svh
// address map, write masks, reset values and field positions of the register bank
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH

// ----------------------------------------------------------------------------
// plain registers: {address, implemented-bit mask, reset value}
// ----------------------------------------------------------------------------
`define SRB_REG_STKPTR   {8'h81, 8'hFF, 8'h07}
`define SRB_REG_P0MA     {8'h84, 8'hFF, 8'hFF}
`define SRB_REG_P0MB     {8'h85, 8'hFF, 8'h00}
`define SRB_REG_PWRCTL   {8'h87, 8'hDF, 8'h00}
`define SRB_REG_TCTL     {8'h88, 8'hFF, 8'h00}
`define SRB_REG_TMODE    {8'h89, 8'hFF, 8'h00}
`define SRB_REG_T0LO     {8'h8A, 8'hFF, 8'h00}
`define SRB_REG_T1LO     {8'h8B, 8'hFF, 8'h00}
`define SRB_REG_T0HI     {8'h8C, 8'hFF, 8'h00}
`define SRB_REG_T1HI     {8'h8D, 8'hFF, 8'h00}
`define SRB_REG_TAUX     {8'h8F, 8'h11, 8'h00}
`define SRB_REG_P1MA     {8'h91, 8'hDF, 8'hD3}
`define SRB_REG_P1MB     {8'h92, 8'hDF, 8'h00}
`define SRB_REG_SCTL     {8'h98, 8'hFF, 8'h00}
`define SRB_REG_SERBUF   {8'h99, 8'hFF, 8'h00}
`define SRB_REG_P2MA     {8'hA4, 8'hFF, 8'hFF}
`define SRB_REG_P2MB     {8'hA5, 8'hFF, 8'h00}
`define SRB_REG_SMADDR   {8'hA9, 8'hFF, 8'h00}
`define SRB_REG_P3MA     {8'hB1, 8'h03, 8'h03}
`define SRB_REG_P3MB     {8'hB2, 8'h03, 8'h00}
`define SRB_REG_PCEXT    {8'hB5, 8'hAE, 8'h00}
`define SRB_REG_SMMASK   {8'hB9, 8'hFF, 8'h00}
`define SRB_REG_SXSTAT   {8'hBA, 8'hFF, 8'h00}
`define SRB_REG_WDLOAD   {8'hC1, 8'hFF, 8'hFF}
`define SRB_REG_PSTAT    {8'hD0, 8'hFF, 8'h00}
`define SRB_REG_RTCCTL   {8'hD1, 8'hE3, 8'h60}
`define SRB_REG_RTCHI    {8'hD2, 8'hFF, 8'h00}
`define SRB_REG_RTCLO    {8'hD3, 8'hFF, 8'h00}
`define SRB_REG_SPISTAT  {8'hE1, 8'hC0, 8'h00}
`define SRB_REG_SPICTL   {8'hE2, 8'hFF, 8'h04}
`define SRB_REG_SPIDATA  {8'hE3, 8'hFF, 8'h00}
`define SRB_REG_P0INDIS  {8'hF6, 8'h3E, 8'h00}

// ----------------------------------------------------------------------------
// special registers
// ----------------------------------------------------------------------------
`define SRB_ADDR_TRIM    8'h96
`define SRB_ADDR_WDCTL   8'hA7
`define SRB_ADDR_FEED1   8'hC2
`define SRB_ADDR_FEED2   8'hC3
`define SRB_ADDR_RCAUSE  8'hDF
`define SRB_MASK_WDCTL   8'hE7
`define SRB_MASK_RCAUSE  8'h7F
`define SRB_RST_WDCTL    8'hE5
`define SRB_RST_RCAUSE   8'h30
`define SRB_RST_TRIM     8'h00
`define SRB_WD_TOF_BIT   1
`define SRB_RC_BOIRQ_BIT 6
`define SRB_RC_BORST_BIT 5
`define SRB_RC_BK_BIT    3
`define SRB_RC_WD_BIT    2
`define SRB_RC_SF_BIT    1
`define SRB_RC_EX_BIT    0

`endif

// file: inc/srb_pkg.sv
// types shared by the register bank and its users
package srb_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srb_bus_req_s;

    typedef struct packed {
        logic wdog;
        logic brownout;
        logic brk;
        logic software;
        logic external;
    } srb_reset_evt_s;

    typedef struct packed {
        logic [7:0] mode_a;
        logic [7:0] mode_b;
    } srb_port_mode_s;

    typedef struct packed {
        logic [2:0] watchdog_prescale_sel;
        logic [1:0] unused;
        logic       watchdog_run;
        logic       watchdog_timeout_flag;
        logic       watchdog_clock_select;
    } srb_wdog_ctl_s;

    typedef struct packed {
        logic       rc_clock_select;
        logic       clock_out_enable;
        logic [5:0] trim_value;
    } srb_trim_s;

    typedef struct packed {
        logic unused;
        logic brownout_irq_flag;
        logic brownout_reset_flag;
        logic power_on_flag;
        logic break_reset_flag;
        logic watchdog_reset_flag;
        logic software_reset_flag;
        logic external_reset_flag;
    } srb_reset_cause_s;

endpackage

// file: tb/srb_cpu_model.sv
// processor core model that issues register reads and writes
`timescale 1ns/1ps

module srb_cpu_model
    import srb_pkg::*;
(
    output srb_bus_req_s    sfr_req,
    input  wire logic       sys_clk,
    input  wire logic [7:0] sfr_rdata
);
    initial sfr_req = '0;

    // one access per call, launched and released just after a falling edge;
    // the idle bus carries the inverse so a stale value never passes for data
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge sys_clk);
        sfr_req = {w, ~w, a, d};
        @(negedge sys_clk);
        q = sfr_rdata;
        sfr_req = {1'h0, 1'h0, ~a, ~d};
    endtask

endmodule // srb_cpu_model

// file: tb/srb_sfr_bank_tb.sv
// self-checking bench for the special function register bank
`timescale 1ns/1ps

module srb_sfr_bank_tb
    import srb_pkg::*;
;
    logic                 sys_clk;
    logic                 rst_n;
    srb_bus_req_s         sfr_req;
    logic [7:0]           sfr_rdata;
    srb_reset_evt_s       reset_evt;
    logic                 brownout_irq;
    logic [7:0]           factory_trim;
    srb_port_mode_s [3:0] port_mode;
    srb_wdog_ctl_s        wdog_ctl;
    srb_trim_s            osc_trim;
    srb_reset_cause_s     reset_cause;
    logic [7:0]           rtc_ctl, spi_ctl, pwr_ctl_ext, serial_ext_status;
    logic [7:0]           timer_ctl, timer_aux_mode, port0_input_disable;
    int                   bad_count = 0;
    int                   cmp_count = 0;
    int                   rc_bit [5] = '{0, 1, 3, 5, 2};
    logic [7:0]           pm_a [4] = '{8'hFF, 8'hD3, 8'hFF, 8'h03};
    logic [7:0]           odd [3] = '{8'h80, 8'hC2, 8'hC3};
    // {address, writable mask, reset value} of every plain register
    logic [23:0]          regs [32] = '{
        24'h81FF07, 24'h84FFFF, 24'h85FF00, 24'h87DF00, 24'h88FF00, 24'h89FF00,
        24'h8AFF00, 24'h8BFF00, 24'h8CFF00, 24'h8DFF00, 24'h8F1100, 24'h91DFD3,
        24'h92DF00, 24'h98FF00, 24'h99FF00, 24'hA4FFFF, 24'hA5FF00, 24'hA9FF00,
        24'hB10303, 24'hB20300, 24'hB5AE00, 24'hB9FF00, 24'hBAFF00, 24'hC1FFFF,
        24'hD0FF00, 24'hD1E360, 24'hD2FF00, 24'hD3FF00, 24'hE1C000, 24'hE2FF04,
        24'hE3FF00, 24'hF63E00};

    srb_sfr_bank i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .reset_evt(reset_evt), .brownout_irq(brownout_irq), .factory_trim(factory_trim),
        .port_mode(port_mode), .wdog_ctl(wdog_ctl), .osc_trim(osc_trim),
        .reset_cause(reset_cause), .rtc_ctl(rtc_ctl), .spi_ctl(spi_ctl),
        .pwr_ctl_ext(pwr_ctl_ext), .serial_ext_status(serial_ext_status),
        .timer_ctl(timer_ctl), .timer_aux_mode(timer_aux_mode),
        .port0_input_disable(port0_input_disable));

    srb_cpu_model i_cpu (.sfr_req(sfr_req), .sys_clk(sys_clk), .sfr_rdata(sfr_rdata));

    // ------------------------------------------------------------------------
    // clock, watchdog, comparison and closing
    // ------------------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        #1_000_000;
        bad_count++;
        summarize();
    end

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

`define CHK(n, e, g) check(n, e, g)

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [7:0] out_at(input logic [7:0] a);
        case (a)
            8'h88: return timer_ctl;
            8'h8F: return timer_aux_mode;
            8'hB5: return pwr_ctl_ext;
            8'hBA: return serial_ext_status;
            8'hD1: return rtc_ctl;
            8'hE2: return spi_ctl;
            default: return port0_input_disable;
        endcase
    endfunction

    // checks the state left by a power-on reset
    task automatic post_por();
        logic [7:0] r;
        @(negedge sys_clk);
        `CHK("cause", 8'h30, reset_cause);
        `CHK("wdog", 8'hE5, wdog_ctl);
        `CHK("trim", factory_trim, osc_trim);
        for (int p = 0; p < 4; p++) begin
            `CHK("mode_a", pm_a[p], port_mode[p].mode_a);
            `CHK("mode_b", 8'h00, port_mode[p].mode_b);
        end
        foreach (regs[i]) begin
            i_cpu.access(1'h0, regs[i][23:16], 8'($urandom), r);
            `CHK("reset", regs[i][7:0], r);
        end
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin : main
        logic [7:0] a, d, r, wd, tr, cause;
        rst_n = 1'h0;
        reset_evt = '0;
        brownout_irq = 1'h0;
        void'($urandom(32'hBDBB));
        factory_trim = 8'($urandom);
        repeat (4) @(negedge sys_clk);
        rst_n = 1'h1;
        post_por();
        $display("test power_on_values done");
        foreach (regs[i]) begin
            a = regs[i][23:16];
            d = 8'($urandom);
            i_cpu.access(1'h1, a, d, r);
            if (a inside {8'h88, 8'h8F, 8'hB5, 8'hBA, 8'hD1, 8'hE2, 8'hF6})
                `CHK("out", d & regs[i][15:8], out_at(a));
            i_cpu.access(1'h0, a, 8'($urandom), r);
            `CHK("readback", d & regs[i][15:8], r);
        end
        foreach (odd[i]) begin
            i_cpu.access(1'h1, odd[i], 8'hFF, r);
            i_cpu.access(1'h0, odd[i], 8'h00, r);
            `CHK("empty", 8'h00, r);
        end
        $display("test write_masks done");
        cause = 8'h30;
        for (int k = 0; k < 5; k++) begin
            wd = 8'($urandom);
            tr = 8'($urandom);
            i_cpu.access(1'h1, 8'hA7, wd, r);
            i_cpu.access(1'h1, 8'h96, tr, r);
            i_cpu.access(1'h1, 8'hE2, 8'hFF, r);
            @(negedge sys_clk);
            reset_evt = srb_reset_evt_s'(5'h01 << k);
            @(negedge sys_clk);
            reset_evt = '0;
            cause[rc_bit[k]] = 1'h1;
            `CHK("cause", cause, reset_cause);
            `CHK("spi", 8'h04, spi_ctl);
            `CHK("wdog", (k == 4) ? 8'hE7 : wd & 8'hE7, wdog_ctl);
            `CHK("trim", (k == 4) ? factory_trim : tr, osc_trim);
            i_cpu.access(1'h0, 8'hA7, 8'h00, r);
            `CHK("wdog_rd", (k == 4) ? 8'hE7 : wd & 8'hE7, r);
            i_cpu.access(1'h0, 8'h96, 8'h00, r);
            `CHK("trim_rd", (k == 4) ? factory_trim : tr, r);
        end
        $display("test reset_sources done");
        @(negedge sys_clk);
        brownout_irq = 1'h1;
        @(negedge sys_clk);
        brownout_irq = 1'h0;
        `CHK("boirq", cause | 8'h40, reset_cause);
        i_cpu.access(1'h0, 8'hDF, 8'h00, r);
        `CHK("cause_rd", cause | 8'h40, r);
        i_cpu.access(1'h1, 8'hDF, 8'h80, r);
        `CHK("cleared", 8'h00, reset_cause);
        $display("test brownout_flag done");
        @(negedge sys_clk);
        rst_n = 1'h0;
        @(negedge sys_clk);
        rst_n = 1'h1;
        post_por();
        $display("test second_power_on done");
        summarize();
    end

endmodule // srb_sfr_bank_tb
